/* core/sdw_ctl.sv */
// Purpose: controller end; issues commands and drives write bursts
// Assumes: link clock is the system clock halved and made here
// Notes: link outputs change when the link clock falls, one link cycle each; req_ready_o is high for half a link cycle
`timescale 1ns/1ns
`default_nettype none
`include "sdw_defines.svh"
module sdw_ctl
	import sdw_pkg::*;
#(
	parameter int DQ_W = 8,
	parameter int ADDR_W = 14,
	parameter int LAT_W = 4,
	parameter logic [6:0] WR_CK = `SDW_WR_CK,
	parameter logic [6:0] WTR_CK = `SDW_WTR_CK
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// link
	sdw_if.ctl link,
	// mode settings, same as the device's
	input wire logic [1:0] burst_field_i,
	input wire logic [LAT_W-1:0] additive_latency_i,
	input wire logic [LAT_W-1:0] cas_write_latency_i,
	// request
	input wire logic req_valid_i,
	input wire sdw_cmd_t req_cmd_i,
	input wire logic [2:0] req_bank_i,
	input wire logic [ADDR_W-1:0] req_addr_i,
	input wire logic req_ap_i,
	input wire logic req_chop_i,
	input wire logic [8*DQ_W-1:0] req_data_i,
	input wire logic [7:0] req_mask_i,
	output logic req_ready_o,
	// status
	output logic [`SDW_NBANK-1:0] bank_open_o,
	output logic err_idle_o
);
	typedef struct packed {
		sdw_slot_k_t k;
		logic [2*DQ_W-1:0] d;
		logic [1:0] m;
	} sdw_slot_t;

	typedef struct packed {
		logic ck;
		logic ready;
		sdw_slot_t [`SDW_SLOT_N-1:0] sl;
		sdw_slot_t drv;
		logic [6:0] ccd;
		logic [6:0] wtr;
		logic [`SDW_NBANK-1:0][6:0] wr;
		logic [`SDW_NBANK-1:0] open;
		logic err;
		sdw_cmd_t cmd;
		logic [2:0] bank;
		logic [ADDR_W-1:0] addr;
		logic scope;
		logic chop;
	} sdw_ctl_st_t;

	localparam sdw_slot_t SL_IDLE = '{k: sdw_sk_idle, d: '0, m: 2'h0};

	sdw_ctl_st_t s, next_s;
	logic [LAT_W:0] wl;
	logic fixed_bc4;
	logic drv_bc4;
	logic ok;

	assign wl = {1'b0, additive_latency_i} + {1'b0, cas_write_latency_i}; // see RULE5
	assign fixed_bc4 = (burst_field_i == `SDW_BF_BC4);
	assign drv_bc4 = fixed_bc4 || ((burst_field_i == `SDW_BF_OTF) && !req_chop_i);

	// spacing checks for the offered request
	always_comb begin
		unique case (req_cmd_i)
			sdw_wr: ok = (s.ccd == 7'h00); // see RULE11
			sdw_rd: ok = (s.wtr == 7'h00); // see RULE12
			sdw_pre: ok = req_ap_i ? (s.wr == '0) : (s.wr[req_bank_i] == 7'h00); // see RULE15
			default: ok = 1'b1;
		endcase
	end

	// whole next state
	always_comb begin
		logic take;
		logic [6:0] tail;
		take = 1'b0;
		tail = 7'h00;
		next_s = s;
		next_s.ck = !s.ck;
		// ready offered in the cycle before the link clock falls
		next_s.ready = !s.ck && req_valid_i && ok;
		if (s.ck) begin
			take = s.ready && req_valid_i;
			next_s.ready = 1'b0;
			next_s.drv = s.sl[0];
			next_s.sl = {SL_IDLE, s.sl[`SDW_SLOT_N-1:1]};
			next_s.cmd = sdw_nop;
			next_s.bank = req_bank_i;
			next_s.addr = req_addr_i;
			next_s.scope = req_ap_i;
			next_s.chop = req_chop_i;
			if (s.ccd != 7'h00) next_s.ccd = 7'(s.ccd - 7'h01);
			if (s.wtr != 7'h00) next_s.wtr = 7'(s.wtr - 7'h01);
			for (int b = 0; b < `SDW_NBANK; b++) begin
				if (s.wr[b] != 7'h00) next_s.wr[b] = 7'(s.wr[b] - 7'h01);
			end
			// on-the-fly chop still waits the full burst time
			tail = 7'(wl) + (fixed_bc4 ? 7'h02 : 7'h04); // see RULE13 see RULE14 see RULE16
			if (take) begin
				unique case (req_cmd_i)
					sdw_wr: begin
						// an idle bank is never written; the request is dropped
						if (!s.open[req_bank_i]) begin
							next_s.err = 1'b1; // see RULE21
						end else begin
							next_s.cmd = sdw_wr; // see RULE1
							next_s.ccd = 7'(`SDW_CCD_CK - 7'h01);
							next_s.wtr = 7'(tail + WTR_CK - 7'h01);
							next_s.wr[req_bank_i] = 7'(tail + WR_CK - 7'h01);
							if (req_ap_i) next_s.open[req_bank_i] = 1'b0;
							for (int j = 0; j < `SDW_SLOT_N; j++) begin
								// preamble only where no earlier data sits
								if (j == int'(wl) - 2 && !next_s.sl[j].k[2]) begin
									next_s.sl[j].k = sdw_sk_pre; // see RULE6
								end
								for (int p = 0; p < 4; p++) begin
									if ((p < 2 || !drv_bc4) && j == int'(wl) - 1 + p) begin
										next_s.sl[j] = '{k: sdw_sk_data, d: req_data_i[p*2*DQ_W +: 2*DQ_W],
											m: req_mask_i[2*p +: 2]}; // see RULE8
									end
								end
								if (j == int'(wl) - 1 + (drv_bc4 ? 2 : 4) && next_s.sl[j].k[0]) begin
									next_s.sl[j].k = sdw_sk_post; // see RULE7
								end
							end
						end
					end
					sdw_rd: begin
						if (!s.open[req_bank_i]) next_s.err = 1'b1;
						else next_s.cmd = sdw_rd;
					end
					sdw_act: begin
						next_s.cmd = sdw_act;
						next_s.open[req_bank_i] = 1'b1;
					end
					sdw_pre: begin
						next_s.cmd = sdw_pre;
						if (req_ap_i) next_s.open = '0;
						else next_s.open[req_bank_i] = 1'b0;
					end
					default: next_s.cmd = sdw_nop;
				endcase
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '{sl: {`SDW_SLOT_N{SL_IDLE}}, drv: SL_IDLE, cmd: sdw_nop, default: '0};
		end else begin
			s <= next_s;
		end
	end

	// link drive; data and strobe follow the slot kind
	assign link.ck = s.ck;
	assign link.cmd = s.cmd;
	assign link.bank = s.bank;
	assign link.addr = s.addr;
	assign link.precharge_scope_bit = s.scope;
	assign link.chop_select_bit = s.chop;
	assign link.write_mask_input = s.drv.m;
	assign link.ctl_dq = s.drv.d;
	assign link.ctl_dq_oe = s.drv.k[2];
	assign link.ctl_dqs_t = s.drv.k[2];
	assign link.ctl_dqs_c = !s.drv.k[2];
	assign link.ctl_dqs_oe = !s.drv.k[0]; // see RULE7
	assign req_ready_o = s.ready;
	assign bank_open_o = s.open;
	assign err_idle_o = s.err;
endmodule : sdw_ctl
`default_nettype wire

/* core/sdw_defines.svh */
// Purpose: shared constants of the write-burst link
// Assumes: counts are in link clock cycles
// Notes: included by both ends only, not by the package or the test files
`ifndef SDW_DEFINES_SVH
`define SDW_DEFINES_SVH
// burst field of mode_register_zero
`define SDW_BF_BL8 2'h0
`define SDW_BF_OTF 2'h1
`define SDW_BF_BC4 2'h2
// index of the last element pair (one pair per link clock) of a burst
`define SDW_PAIRS_BL8 2'h3
`define SDW_PAIRS_BC4 2'h1
// link clock counts
`define SDW_CCD_CK 7'h04
`define SDW_WTR_CK 7'h04
`define SDW_WR_CK 7'h08
// structure sizes
`define SDW_DL_N 32
`define SDW_SLOT_N 40
`define SDW_NBANK 8
`endif

/* core/sdw_pkg.sv */
// Purpose: types shared by both ends of the write-burst link
// Assumes: nothing
// Notes: command codes are link encodings, not states
package sdw_pkg;
	// link command
	typedef enum logic [2:0] {
		sdw_nop = 3'h0,
		sdw_act = 3'h1,
		sdw_wr = 3'h2,
		sdw_rd = 3'h3,
		sdw_pre = 3'h4
	} sdw_cmd_t;
	// device burst state
	typedef enum logic [1:0] {
		sdw_idle = 2'b01,
		sdw_burst = 2'b10
	} sdw_bst_t;
	// what the controller drives in one link cycle
	typedef enum logic [3:0] {
		sdw_sk_idle = 4'b0001,
		sdw_sk_pre = 4'b0010,
		sdw_sk_data = 4'b0100,
		sdw_sk_post = 4'b1000
	} sdw_slot_k_t;
endpackage : sdw_pkg

/* core/sdw_if.sv */
// Purpose: link between memory controller and write path
// Assumes: controller makes the link clock
// Notes: two-way wires are resolved here from the enables
`timescale 1ns/1ns
`default_nettype none
interface sdw_if #(
	parameter int DQ_W = 8,
	parameter int ADDR_W = 14
);
	logic ck;
	sdw_pkg::sdw_cmd_t cmd;
	logic [2:0] bank;
	logic [ADDR_W-1:0] addr;
	logic precharge_scope_bit;
	logic chop_select_bit;
	logic [1:0] write_mask_input;
	logic [2*DQ_W-1:0] ctl_dq;
	logic ctl_dq_oe;
	logic [2*DQ_W-1:0] dev_dq;
	logic dev_dq_oe;
	logic [2*DQ_W-1:0] dq;
	logic ctl_dqs_t;
	logic ctl_dqs_c;
	logic ctl_dqs_oe;
	logic dqs_t;
	logic dqs_c;
	logic dqs_on;
	// wire levels; an undriven pair reads low
	assign dq = ctl_dq_oe ? ctl_dq : (dev_dq_oe ? dev_dq : '0);
	assign dqs_t = ctl_dqs_oe & ctl_dqs_t;
	assign dqs_c = ctl_dqs_oe & ctl_dqs_c;
	assign dqs_on = ctl_dqs_oe;
	modport ctl (output ck, cmd, bank, addr, precharge_scope_bit, chop_select_bit, write_mask_input,
		ctl_dq, ctl_dq_oe, ctl_dqs_t, ctl_dqs_c, ctl_dqs_oe, input dq);
	modport dev (input ck, cmd, bank, addr, precharge_scope_bit, chop_select_bit, write_mask_input,
		dq, dqs_t, dqs_c, dqs_on, output dev_dq, dev_dq_oe);
endinterface : sdw_if
`default_nettype wire

/* core/sdw_sync.sv */
// Purpose: two-flop level synchroniser
// Assumes: bits are quasi-static settings
// Notes: a multi-bit word is only safe if it changes while idle
`timescale 1ns/1ns
`default_nettype none
module sdw_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// level in and out
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] a;
		logic [W-1:0] b;
	} sdw_sync_st_t;
	sdw_sync_st_t s, next_s;

	// first stage feeds only the second
	always_comb begin
		next_s.a = d_i;
		next_s.b = s.a;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q_o = s.b;
endmodule : sdw_sync
`default_nettype wire

/* core/sdw_dev.sv */
// Purpose: memory-side write path and bank precharge
// Assumes: link commands and data are launched by the controller on the
//   falling link clock, so every rising edge samples settled values
// Notes: one link cycle carries an element pair: low half at the rising
//   strobe, high half at the falling strobe
//
// Contract
// RULE1: write latches bank, column, auto-precharge choice
// RULE2: auto precharge closes row after burst
// RULE3: accepted write burst always runs complete; here a write reaching the latency tap mid-burst restarts it
// RULE4: first element at rising strobe after latency
// RULE5: write latency is additive plus cas latency
// RULE6: controller drives one-cycle preamble before data
// RULE7: controller drives half-cycle postamble, then releases; the controller holds it one full link cycle
// RULE8: first strobe edge latency clocks after command
// RULE9: high mask blocks the element's store
// RULE10: after burst, data ignored, lines undriven
// RULE11: back-to-back writes give continuous data
// RULE12: read waits write-to-read delay after data
// RULE13: fixed chop counts delay after last data
// RULE14: on-the-fly chop counts delay after burst time
// RULE15: precharge waits write recovery after data
// RULE16: fixed chop recovery counts after last data
// RULE17: eight beats for field 00 or 01+chop high
// RULE18: field 10 gives fixed four-beat chop
// RULE19: on-the-fly mode, chop low gives four beats
// RULE20: scope bit picks one bank or all
// RULE21: precharged bank idle until activated again
`timescale 1ns/1ns
`default_nettype none
`include "sdw_defines.svh"
module sdw_dev
	import sdw_pkg::*;
#(
	parameter int DQ_W = 8,
	parameter int ADDR_W = 14,
	parameter int LAT_W = 4
) (
	// reset, acts on the link clock domain
	input wire logic rst_i,
	// link
	sdw_if.dev link,
	// mode settings, quasi-static
	input wire logic [1:0] burst_field_i,
	input wire logic [LAT_W-1:0] additive_latency_i,
	input wire logic [LAT_W-1:0] cas_write_latency_i,
	// element store port
	output logic [1:0] store_valid_o,
	output logic [2:0] store_bank_o,
	output logic [ADDR_W-1:0] store_col0_o,
	output logic [ADDR_W-1:0] store_col1_o,
	output logic [2*DQ_W-1:0] store_data_o,
	// status
	output logic [`SDW_NBANK-1:0] bank_open_o,
	output logic burst_active_o,
	output logic err_idle_o
);
	// write command as held in the latency line
	typedef struct packed {
		logic v;
		logic [2:0] bank;
		logic [ADDR_W-1:0] col;
		logic ap;
		logic bc4;
	} sdw_wcmd_t;

	typedef struct packed {
		sdw_wcmd_t [`SDW_DL_N-1:0] dl;
		sdw_bst_t st;
		sdw_wcmd_t cur;
		logic [1:0] pair;
		logic [`SDW_NBANK-1:0] open;
		logic err;
		logic busy;
		logic [1:0] sv;
		logic [2:0] sbank;
		logic [ADDR_W-1:0] scol0;
		logic [ADDR_W-1:0] scol1;
		logic [2*DQ_W-1:0] sdata;
	} sdw_dev_st_t;

	sdw_dev_st_t s, next_s;
	logic [2*LAT_W+1:0] cfg;
	logic [1:0] bf;
	logic [LAT_W:0] wl;

	// settings come from another domain, so resynchronise
	sdw_sync #(
		.W(2*LAT_W+2)
	) u_cfg (
		.clk_i(link.ck),
		.rst_i(rst_i),
		.d_i({burst_field_i, additive_latency_i, cas_write_latency_i}),
		.q_o(cfg)
	);

	assign bf = cfg[2*LAT_W+1:2*LAT_W];
	// latency must be at least one; zero would wrap the line index
	assign wl = {1'b0, cfg[2*LAT_W-1:LAT_W]} + {1'b0, cfg[LAT_W-1:0]}; // see RULE5

	// burst order: chop wraps within four, full burst within eight
	function automatic logic [ADDR_W-1:0] sdw_col_at(input logic [ADDR_W-1:0] c, input logic bc4,
		input logic [2:0] k);
		logic [ADDR_W-1:0] r;
		r = c;
		if (bc4) begin
			r[1:0] = c[1:0] + k[1:0];
		end else begin
			r[2:0] = c[2:0] + k;
		end
		return r;
	endfunction : sdw_col_at

	// whole next state
	always_comb begin
		sdw_wcmd_t nw;
		sdw_wcmd_t ctx;
		logic [1:0] pr;
		logic go;
		logic stb;
		nw = '0;
		ctx = '0;
		pr = 2'h0;
		go = 1'b0;
		stb = 1'b0;
		next_s = s;
		next_s.sv = 2'h0;

		// capture bank, column and precharge choice with the command
		nw.v = (link.cmd == sdw_wr); // see RULE1
		nw.bank = link.bank;
		nw.col = link.addr;
		nw.ap = link.precharge_scope_bit;
		// chop decided per access from field and chop bit
		nw.bc4 = (bf == `SDW_BF_BC4) // see RULE18
			|| ((bf == `SDW_BF_OTF) && !link.chop_select_bit); // see RULE17 see RULE19
		next_s.dl = {s.dl[`SDW_DL_N-2:0], nw};
		// a write to an idle bank is flagged; its data still runs
		if (nw.v && !s.open[nw.bank]) begin
			next_s.err = 1'b1; // see RULE21
		end

		// a command reaching the latency tap starts a burst now
		go = s.dl[5'(wl - 5'h01)].v; // see RULE4
		// a fresh start directly after the last pair keeps data continuous
		ctx = go ? s.dl[5'(wl - 5'h01)] : s.cur; // see RULE11
		pr = go ? 2'h0 : s.pair;
		stb = link.dqs_on && link.dqs_t && !link.dqs_c;

		if (go || s.busy) begin
			// masked or strobeless elements are not stored
			next_s.sv = stb ? ~link.write_mask_input : 2'h0; // see RULE9
			next_s.sbank = ctx.bank;
			next_s.scol0 = sdw_col_at(ctx.col, ctx.bc4, {pr, 1'b0});
			next_s.scol1 = sdw_col_at(ctx.col, ctx.bc4, {pr, 1'b1});
			next_s.sdata = link.dq;
			// the pair count ends a burst, unless a new command reaching the latency tap cuts it short
			if (pr == (ctx.bc4 ? `SDW_PAIRS_BC4 : `SDW_PAIRS_BL8)) begin // see RULE3
				next_s.st = sdw_idle;
				next_s.busy = 1'b0;
				if (ctx.ap) begin
					next_s.open[ctx.bank] = 1'b0; // see RULE2
				end
			end else begin
				next_s.st = sdw_burst;
				next_s.busy = 1'b1;
				next_s.cur = ctx;
				next_s.pair = 2'(pr + 2'h1);
			end
		end

		// bank commands; auto close above is overridden by a later activate
		if (link.cmd == sdw_act) begin
			next_s.open[link.bank] = 1'b1;
		end else if (link.cmd == sdw_pre) begin
			if (link.precharge_scope_bit) begin
				next_s.open = '0; // see RULE20
			end else begin
				next_s.open[link.bank] = 1'b0; // see RULE20
			end
		end
	end

	// state register on the link clock
	always_ff @(posedge link.ck or posedge rst_i) begin
		if (rst_i) begin
			s <= '{st: sdw_idle, default: '0};
		end else begin
			s <= next_s;
		end
	end

	// write path never drives the data lines
	assign link.dev_dq = '0; // see RULE10
	assign link.dev_dq_oe = 1'b0; // see RULE10

	// user-side outputs
	assign store_valid_o = s.sv;
	assign store_bank_o = s.sbank;
	assign store_col0_o = s.scol0;
	assign store_col1_o = s.scol1;
	assign store_data_o = s.sdata;
	assign bank_open_o = s.open;
	assign burst_active_o = s.busy;
	assign err_idle_o = s.err;
endmodule : sdw_dev
`default_nettype wire

/* test/sdw_monitor.sv */
// Purpose: link-side checker for the write-burst link
// Assumes: all checks on the rising link clock
// Notes: WL must match the latency settings given to both ends
`timescale 1ns/1ns
`default_nettype none
module sdw_monitor
	import sdw_pkg::*;
#(
	parameter int WL = 5
) (
	// reset and link clock
	input wire logic rst_i,
	input wire logic ck,
	// command lines
	input wire sdw_cmd_t cmd,
	input wire logic [2:0] bank,
	input wire logic precharge_scope_bit,
	// strobe and data enables
	input wire logic dqs_t,
	input wire logic dqs_c,
	input wire logic dqs_on,
	input wire logic ctl_dq_oe,
	input wire logic dev_dq_oe
);
	typedef struct packed {logic [3:0] since; logic [2:0] wbank;} sdw_mon_t;
	sdw_mon_t st;
	sdw_mon_t next_st;
	// cycles since the last data cycle, saturating; bank of the last write
	always_comb begin
		next_st = st;
		if (dqs_on && dqs_t) begin
			next_st.since = 4'h0;
		end else if (st.since != 4'hF) begin
			next_st.since = st.since + 4'h1;
		end
		if (cmd == sdw_wr) begin
			next_st.wbank = bank;
		end
	end
	// starts saturated so commands before any write pass
	always_ff @(posedge ck or posedge rst_i) begin
		if (rst_i) begin
			st <= '{since: 4'hF, wbank: 3'h0};
		end else begin
			st <= next_st;
		end
	end
	default clocking cb @(posedge ck); endclocking
	default disable iff (rst_i);
	property p_dev_quiet;
		!dev_dq_oe;
	endproperty
	a_dev_quiet: assert property (p_dev_quiet) else $error("device drove data lines");
	property p_first_edge;
		cmd == sdw_wr |-> ##WL (dqs_on && dqs_t && !dqs_c);
	endproperty
	a_first_edge: assert property (p_first_edge) else $error("first data not at latency");
	property p_preamble;
		$rose(dqs_on) |-> (!dqs_t && dqs_c) ##1 (dqs_t && !dqs_c);
	endproperty
	a_preamble: assert property (p_preamble) else $error("bad strobe preamble");
	property p_release;
		$fell(dqs_on) |-> $past(dqs_c) && !$past(dqs_t);
	endproperty
	a_release: assert property (p_release) else $error("strobe released without postamble");
	property p_data_driven;
		dqs_on && dqs_t |-> ctl_dq_oe && !dqs_c;
	endproperty
	a_data_driven: assert property (p_data_driven) else $error("data strobe without data");
	property p_ccd;
		cmd == sdw_wr |=> (cmd != sdw_wr) [*3];
	endproperty
	a_ccd: assert property (p_ccd) else $error("writes closer than four cycles");
	property p_wtr;
		cmd == sdw_rd |-> st.since >= 4'h4;
	endproperty
	a_wtr: assert property (p_wtr) else $error("read too soon after data");
	property p_wr_rec;
		cmd == sdw_pre && (precharge_scope_bit || bank == st.wbank) |-> st.since >= 4'h8;
	endproperty
	a_wr_rec: assert property (p_wr_rec) else $error("precharge inside recovery");
	// main scenarios
	cover property (cmd == sdw_wr ##4 cmd == sdw_wr);
	cover property (cmd == sdw_pre && precharge_scope_bit);
	cover property (cmd == sdw_rd);
endmodule : sdw_monitor
`default_nettype wire

/* test/testbench.sv */
// Purpose: joins both ends and checks stored elements and bank state
// Assumes: latency settings fixed at one plus five
// Notes: stores are sampled mid link cycle
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import sdw_pkg::*;
	// clock, reset, settings
	logic sys_clk_i;
	logic rst_i;
	logic [1:0] burst_field;
	logic [3:0] add_lat;
	logic [3:0] cas_lat;
	// request port
	logic req_valid;
	sdw_cmd_t req_cmd;
	logic [2:0] req_bank;
	logic [13:0] req_addr;
	logic req_ap;
	logic req_chop;
	logic [63:0] req_data;
	logic [7:0] req_mask;
	logic req_ready;
	logic [7:0] ctl_open;
	logic ctl_err;
	// device outputs
	logic [1:0] store_valid;
	logic [2:0] store_bank;
	logic [13:0] store_col0;
	logic [13:0] store_col1;
	logic [15:0] store_data;
	logic [7:0] dev_open;
	logic burst_active;
	logic dev_err;
	int err_count;
	int total_checks;
	logic [31:0] exp_q[$];
	logic [31:0] got_q[$];
	sdw_if #(.DQ_W(8), .ADDR_W(14)) sdw_if_i ();
	sdw_ctl sdw_ctl_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(sdw_if_i.ctl), .burst_field_i(burst_field),
		.additive_latency_i(add_lat), .cas_write_latency_i(cas_lat), .req_valid_i(req_valid), .req_cmd_i(req_cmd),
		.req_bank_i(req_bank), .req_addr_i(req_addr), .req_ap_i(req_ap), .req_chop_i(req_chop),
		.req_data_i(req_data), .req_mask_i(req_mask), .req_ready_o(req_ready), .bank_open_o(ctl_open),
		.err_idle_o(ctl_err));
	sdw_dev sdw_dev_i (.rst_i(rst_i), .link(sdw_if_i.dev), .burst_field_i(burst_field), .additive_latency_i(add_lat),
		.cas_write_latency_i(cas_lat), .store_valid_o(store_valid), .store_bank_o(store_bank),
		.store_col0_o(store_col0), .store_col1_o(store_col1), .store_data_o(store_data), .bank_open_o(dev_open),
		.burst_active_o(burst_active), .err_idle_o(dev_err));
	sdw_monitor #(.WL(6)) sdw_monitor_i (.rst_i(rst_i), .ck(sdw_if_i.ck), .cmd(sdw_if_i.cmd), .bank(sdw_if_i.bank),
		.precharge_scope_bit(sdw_if_i.precharge_scope_bit), .dqs_t(sdw_if_i.dqs_t), .dqs_c(sdw_if_i.dqs_c),
		.dqs_on(sdw_if_i.dqs_on), .ctl_dq_oe(sdw_if_i.ctl_dq_oe), .dev_dq_oe(sdw_if_i.dev_dq_oe));
	// system clock
	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	// element stores, taken mid cycle where they are settled
	always @(negedge sdw_if_i.ck) begin
		if (store_valid[0] === 1'b1) got_q.push_back({7'h00, store_bank, store_col0, store_data[7:0]});
		if (store_valid[1] === 1'b1) got_q.push_back({7'h00, store_bank, store_col1, store_data[15:8]});
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// request held until the edge after ready is seen
	task automatic send(input sdw_cmd_t c, input logic [2:0] b, input logic [13:0] a, input logic ap,
		input logic ch, input logic [63:0] d, input logic [7:0] m);
		@(negedge sys_clk_i);
		req_cmd = c;
		{req_bank, req_addr, req_ap, req_chop, req_data, req_mask} = {b, a, ap, ch, d, m};
		req_valid = 1'b1;
		do @(negedge sys_clk_i); while (req_ready !== 1'b1);
		@(negedge sys_clk_i);
		req_valid = 1'b0;
	endtask : send
	// expected elements in wrap order, masked ones left out
	task automatic wr(input logic [2:0] b, input logic [13:0] c, input logic ap, input logic ch,
		input logic [63:0] d, input logic [7:0] m, input int n);
		logic [2:0] i;
		for (int e = 0; e < n; e++) begin
			i = e[2:0];
			if (!m[e]) exp_q.push_back({7'h00, b, n == 8 ? {c[13:3], c[2:0] + i} : {c[13:2], c[1:0] + i[1:0]}, d[e*8+:8]});
		end
		send(sdw_wr, b, c, ap, ch, d, m);
	endtask : wr
	task automatic settle;
		repeat (40) @(negedge sys_clk_i);
		chk(32'(got_q.size()), 32'(exp_q.size()));
		while (got_q.size() > 0 && exp_q.size() > 0) chk(got_q.pop_front(), exp_q.pop_front());
		got_q.delete();
		exp_q.delete();
	endtask : settle
	// every burst field, chop bit both ways in on-the-fly mode
	task automatic t_modes;
		send(sdw_act, 3'h1, 14'h0012, 1'b0, 1'b0, '0, '0);
		for (int k = 0; k < 4; k++) begin
			@(negedge sys_clk_i);
			burst_field = k == 3 ? 2'h1 : k[1:0];
			repeat (10) @(negedge sys_clk_i);
			wr(3'h1, 14'h0105 + 14'(k), 1'b0, k != 3, 64'h8877665544332211 + 64'(k), 8'h24, k >= 2 ? 4 : 8);
			settle;
		end
	endtask : t_modes
	// concatenated writes, then a read that must wait
	task automatic t_b2b;
		@(negedge sys_clk_i);
		burst_field = 2'h0;
		repeat (10) @(negedge sys_clk_i);
		wr(3'h1, 14'h0010, 1'b0, 1'b1, 64'h0F1E2D3C4B5A6978, 8'h00, 8);
		wr(3'h1, 14'h001B, 1'b0, 1'b1, 64'hA1B2C3D4E5F60718, 8'h81, 8);
		send(sdw_rd, 3'h1, 14'h0010, 1'b0, 1'b1, '0, '0);
		settle;
		chk(32'(dev_open), 32'h02);
	endtask : t_b2b
	// auto precharge, write to idle bank, single and all-bank precharge
	task automatic t_pre;
		wr(3'h1, 14'h0020, 1'b1, 1'b1, 64'h1122334455667788, 8'h00, 8);
		// mid burst: data edges are link edges six to nine after the command
		repeat (14) @(negedge sys_clk_i);
		chk(32'(burst_active), 32'h1);
		settle;
		chk(32'(burst_active), 32'h0);
		chk(32'(dev_open), 32'h00);
		chk(32'(ctl_open), 32'h00);
		send(sdw_wr, 3'h1, 14'h0028, 1'b0, 1'b1, '1, '0);
		settle;
		chk(32'(ctl_err), 32'h1);
		send(sdw_act, 3'h2, 14'h0040, 1'b0, 1'b0, '0, '0);
		send(sdw_act, 3'h3, 14'h0041, 1'b0, 1'b0, '0, '0);
		wr(3'h3, 14'h0006, 1'b0, 1'b1, 64'hCAFE0123BEEF4567, 8'h10, 8);
		send(sdw_pre, 3'h3, 14'h0000, 1'b0, 1'b0, '0, '0);
		settle;
		chk(32'(dev_open), 32'h04);
		send(sdw_pre, 3'h5, 14'h0000, 1'b1, 1'b0, '0, '0);
		repeat (8) @(negedge sys_clk_i);
		chk(32'(dev_open), 32'h00);
		chk(32'(dev_err), 32'h0);
	endtask : t_pre
	task automatic summarize;
		$display("checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
	// main sequence
	initial begin
		err_count = 0;
		total_checks = 0;
		rst_i = 1'b1;
		burst_field = 2'h0;
		add_lat = 4'h1;
		cas_lat = 4'h5;
		req_valid = 1'b0;
		req_cmd = sdw_nop;
		{req_bank, req_addr, req_ap, req_chop, req_data, req_mask} = '0;
		repeat (5) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		rst_i = 1'b0;
		repeat (10) @(negedge sys_clk_i);
		t_modes;
		t_b2b;
		t_pre;
		summarize;
	end
	// hang guard, far beyond the few hundred cycles needed
	initial begin
		#(40 * 20000);
		err_count++;
		summarize;
	end
endmodule : testbench
`default_nettype wire
